//--- rtl/dlr_pkg.sv
package dlr_pkg;
  localparam logic [7:0]  OP_DEFECT_READ   = 8'hB7;
  localparam logic [7:0]  OP_LONG_READ     = 8'h3E;
  localparam logic [2:0]  FMT_BYTE_INDEX   = 3'h4;
  localparam logic [2:0]  FMT_SECTOR       = 3'h5;
  localparam int          CDB_MAX          = 12;
  localparam int          DFT_CDB_LEN      = 12;
  localparam int          LNG_CDB_LEN      = 10;
  localparam int          B1_PRIMARY       = 4;
  localparam int          B1_GROWN         = 3;
  localparam int          B1_WHOLE_PB      = 2;
  localparam int          B1_CORRECT       = 1;
  localparam int          HDR_LEN          = 8;
  localparam int          DESC_LEN         = 8;
  localparam logic [1:0]  STAT_GOOD        = 2'h0;
  localparam logic [1:0]  STAT_CHECK       = 2'h1;
  localparam logic [3:0]  KEY_NONE         = 4'h0;
  localparam logic [3:0]  KEY_RECOVERED    = 4'h1;
  localparam logic [3:0]  KEY_MEDIUM       = 4'h3;
  localparam logic [3:0]  KEY_ILLEGAL      = 4'h5;
  localparam logic [7:0]  ASC_NONE         = 8'h00;
  localparam logic [7:0]  ASC_INVALID_CDB  = 8'h24;
  localparam logic [7:0]  ASC_NO_DEFECTS   = 8'h1C;
  localparam logic [7:0]  ASC_UNRECOVERED  = 8'h11;

  typedef enum logic [2:0] {
    DLR_IDLE   = 3'b000,
    DLR_CDB    = 3'b001,
    DLR_DECODE = 3'b011,
    DLR_SEND   = 3'b010,
    DLR_FETCH  = 3'b110,
    DLR_DONE   = 3'b111
  } dlr_state_t;
endpackage : dlr_pkg

//--- rtl/dlr_cmd.sv
`timescale 1ns/1ns
// Contract
// - defect read B7h, list bits, length 6-9
// - eight byte header, echo bits, list length in bytes
// - descriptors packed, eight bytes each
// - byte format: cyl, head, sector*bps
// - sector format: cyl, head, sector
// - long read 3Eh, block bit, correct, lba, length
// - long read sends one block, no code bytes
// - exponent nonzero, block bit: whole physical block
// - exponent nonzero, no block bit: logical only
// - exponent zero with block bit: illegal request
// - correct bit selects media error report
// - length mismatch: illegal request check
// - mismatch sets valid, flag, difference
// - expected length is the block size sent, logical or physical
// - long read bypasses the data cache
// - exponent zero or power-of-two ratio
// - stop at allocation length or list end
// - unsupported format: sector list, 01h/1Ch
module dlr_cmd
  import dlr_pkg::*;
#(
  parameter int IDX_W = 16
) (
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst,
  input  wire logic              i_cdb_valid,
  input  wire logic [7:0]        i_cdb_byte,
  input  wire logic              i_cdb_last,
  input  wire logic [3:0]        i_lb_per_pb_exp,
  input  wire logic [15:0]       i_lb_size,
  input  wire logic [15:0]       i_bytes_per_sector,
  input  wire logic [31:0]       i_defect_count,
  input  wire logic [23:0]       i_def_cyl,
  input  wire logic [7:0]        i_def_head,
  input  wire logic [31:0]       i_def_sector,
  input  wire logic [7:0]        i_media_byte,
  input  wire logic              i_media_valid,
  input  wire logic              i_corr_failed,
  input  wire logic              i_din_ready,
  output logic [IDX_W-1:0]       o_def_index,
  output logic                   o_media_req,
  output logic [31:0]            o_media_lba,
  output logic [31:0]            o_media_len,
  output logic                   o_media_cache_bypass,
  output logic                   o_din_valid,
  output logic [7:0]             o_din_byte,
  output logic                   o_done,
  output logic [1:0]             o_status,
  output logic [3:0]             o_sense_key,
  output logic [7:0]             o_sense_asc,
  output logic                   o_sense_valid,
  output logic                   o_length_mismatch_flag,
  output logic [31:0]            o_sense_info
);

  function automatic logic [7:0] be_byte(input logic [31:0] w,
                                         input logic [1:0]  i);
    be_byte = w[(3 - i) * 8 +: 8];
  endfunction : be_byte

  dlr_state_t   state;
  dlr_state_t   next_state;
  logic [7:0]   cdb [CDB_MAX];
  logic [3:0]   cdb_cnt;
  logic [31:0]  pos;
  logic [31:0]  limit;
  logic [2:0]   ret_fmt;
  logic         is_long;
  logic [1:0]   fin_status;
  logic [3:0]   fin_key;
  logic [7:0]   fin_asc;
  logic         fin_valid;
  logic         fin_lmf;
  logic [31:0]  fin_info;

  logic [3:0]   next_cdb_cnt;
  logic [31:0]  next_pos;
  logic [31:0]  next_limit;
  logic [2:0]   next_ret_fmt;
  logic         next_is_long;
  logic [1:0]   next_fin_status;
  logic [3:0]   next_fin_key;
  logic [7:0]   next_fin_asc;
  logic         next_fin_valid;
  logic         next_fin_lmf;
  logic [31:0]  next_fin_info;
  logic [IDX_W-1:0] next_def_index;
  logic         next_media_req;
  logic [31:0]  next_media_lba;
  logic [31:0]  next_media_len;
  logic         next_din_valid;
  logic [7:0]   next_din_byte;
  logic         next_done;

  logic [31:0]  alloc_len;
  logic [31:0]  list_bytes;
  logic [31:0]  total_len;
  logic [15:0]  req_len;
  logic [31:0]  avail_len;
  logic [31:0]  desc_byte_off;
  logic [31:0]  bfi;
  logic [7:0]   cur_byte;
  logic         hs;
  logic [3:0]   cdb_wr;

  assign hs = o_din_valid & i_din_ready;
  // bytes past the longest block land on its last slot
  assign cdb_wr = (state == DLR_IDLE) ? 4'h0
                : (cdb_cnt >= 4'(CDB_MAX)) ? 4'(CDB_MAX - 1) : cdb_cnt;
  assign alloc_len = {cdb[6], cdb[7], cdb[8], cdb[9]};
  assign list_bytes = i_defect_count << 3;
  assign total_len = list_bytes + 32'(HDR_LEN);
  assign req_len = {cdb[7], cdb[8]};
  // whole physical block when asked and several blocks share one
  assign avail_len = (cdb[1][B1_WHOLE_PB] && i_lb_per_pb_exp != 4'h0)
                   ? ({16'h0000, i_lb_size} << i_lb_per_pb_exp)
                   : {16'h0000, i_lb_size};
  assign desc_byte_off = pos - 32'(HDR_LEN);
  assign bfi = i_def_sector * {16'h0000, i_bytes_per_sector};

  always_comb begin
    unique case (desc_byte_off[2:0])
      3'h0:    cur_byte = i_def_cyl[23:16];
      3'h1:    cur_byte = i_def_cyl[15:8];
      3'h2:    cur_byte = i_def_cyl[7:0];
      3'h3:    cur_byte = i_def_head;
      default: cur_byte = (ret_fmt == FMT_BYTE_INDEX)
                        ? be_byte(bfi, desc_byte_off[1:0])
                        : be_byte(i_def_sector, desc_byte_off[1:0]);
    endcase
  end

  always_comb begin
    next_state      = state;
    next_cdb_cnt    = cdb_cnt;
    next_pos        = pos;
    next_limit      = limit;
    next_ret_fmt    = ret_fmt;
    next_is_long    = is_long;
    next_fin_status = fin_status;
    next_fin_key    = fin_key;
    next_fin_asc    = fin_asc;
    next_fin_valid  = fin_valid;
    next_fin_lmf    = fin_lmf;
    next_fin_info   = fin_info;
    next_def_index  = o_def_index;
    next_media_req  = 1'b0;
    next_media_lba  = o_media_lba;
    next_media_len  = o_media_len;
    next_din_valid  = o_din_valid;
    next_din_byte   = o_din_byte;
    next_done       = 1'b0;
    unique case (state)
      DLR_IDLE: begin
        next_cdb_cnt = 4'h0;
        if (i_cdb_valid) begin
          next_cdb_cnt = 4'h1;
          next_state   = i_cdb_last ? DLR_DECODE : DLR_CDB;
        end
      end
      DLR_CDB: begin
        if (i_cdb_valid) begin
          if (cdb_cnt != 4'(CDB_MAX + 1))
            next_cdb_cnt = cdb_cnt + 4'h1;
          if (i_cdb_last)
            next_state = DLR_DECODE;
        end
      end
      DLR_DECODE: begin
        next_pos        = 32'h0;
        next_def_index  = '0;
        next_fin_status = STAT_GOOD;
        next_fin_key    = KEY_NONE;
        next_fin_asc    = ASC_NONE;
        next_fin_valid  = 1'b0;
        next_fin_lmf    = 1'b0;
        next_fin_info   = 32'h0;
        next_state      = DLR_SEND;
        if (cdb[0] == OP_DEFECT_READ && cdb_cnt == 4'(DFT_CDB_LEN)) begin
          next_is_long = 1'b0;
          if (cdb[1][2:0] == FMT_BYTE_INDEX) begin
            next_ret_fmt = FMT_BYTE_INDEX;
          end else begin
            next_ret_fmt    = FMT_SECTOR;
            if (cdb[1][2:0] != FMT_SECTOR) begin
              next_fin_status = STAT_CHECK;
              next_fin_key    = KEY_RECOVERED;
              next_fin_asc    = ASC_NO_DEFECTS;
            end
          end
          next_limit = (alloc_len < total_len) ? alloc_len
                                               : total_len;
        end else if (cdb[0] == OP_LONG_READ
                     && cdb_cnt == 4'(LNG_CDB_LEN)) begin
          next_is_long = 1'b1;
          next_limit   = avail_len;
          if (cdb[1][B1_WHOLE_PB] && i_lb_per_pb_exp == 4'h0) begin
            next_fin_status = STAT_CHECK;
            next_fin_key    = KEY_ILLEGAL;
            next_fin_asc    = ASC_INVALID_CDB;
            next_state      = DLR_DONE;
          end else if (req_len != 16'h0000
                       && {16'h0000, req_len} != avail_len) begin
            next_fin_status = STAT_CHECK;
            next_fin_key    = KEY_ILLEGAL;
            next_fin_asc    = ASC_INVALID_CDB;
            next_fin_valid  = 1'b1;
            next_fin_lmf    = 1'b1;
            next_fin_info   = {16'h0000, req_len} - avail_len;
            next_state      = DLR_DONE;
          end else begin
            next_media_req = 1'b1;
            next_media_lba = {cdb[2], cdb[3], cdb[4], cdb[5]};
            next_media_len = avail_len;
          end
        end else begin
          next_fin_status = STAT_CHECK;
          next_fin_key    = KEY_ILLEGAL;
          next_fin_asc    = ASC_INVALID_CDB;
          next_state      = DLR_DONE;
        end
      end
      DLR_SEND: begin
        if (hs) begin
          next_din_valid = 1'b0;
          next_pos       = pos + 32'h1;
          if (!is_long && pos >= 32'(HDR_LEN)
              && desc_byte_off[2:0] == 3'h7)
            next_def_index = o_def_index + IDX_W'(1);
        end else if (!o_din_valid) begin
          if (pos >= limit) begin
            next_state = DLR_DONE;
          end else if (is_long) begin
            next_state = DLR_FETCH;
          end else begin
            next_din_valid = 1'b1;
            unique case (pos[2:0])
              3'h1:    next_din_byte = {3'h0, cdb[1][B1_PRIMARY],
                                        cdb[1][B1_GROWN], ret_fmt};
              3'h4:    next_din_byte = be_byte(list_bytes, 2'h0);
              3'h5:    next_din_byte = be_byte(list_bytes, 2'h1);
              3'h6:    next_din_byte = be_byte(list_bytes, 2'h2);
              3'h7:    next_din_byte = be_byte(list_bytes, 2'h3);
              default: next_din_byte = 8'h00;
            endcase
            if (pos >= 32'(HDR_LEN))
              next_din_byte = cur_byte;
          end
        end
      end
      DLR_FETCH: begin
        if (i_media_valid) begin
          next_din_valid = 1'b1;
          next_din_byte  = i_media_byte;
          next_state     = DLR_SEND;
        end
      end
      DLR_DONE: begin
        if (is_long && i_corr_failed && cdb[1][B1_CORRECT]
            && fin_status == STAT_GOOD) begin
          next_fin_status = STAT_CHECK;
          next_fin_key    = KEY_MEDIUM;
          next_fin_asc    = ASC_UNRECOVERED;
        end
        next_done  = 1'b1;
        next_state = DLR_IDLE;
      end
      default: next_state = DLR_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state                  <= DLR_IDLE;
      cdb_cnt                <= 4'h0;
      pos                    <= 32'h0;
      limit                  <= 32'h0;
      ret_fmt                <= FMT_SECTOR;
      is_long                <= 1'b0;
      fin_status             <= STAT_GOOD;
      fin_key                <= KEY_NONE;
      fin_asc                <= ASC_NONE;
      fin_valid              <= 1'b0;
      fin_lmf                <= 1'b0;
      fin_info               <= 32'h0;
      o_def_index            <= '0;
      o_media_req            <= 1'b0;
      o_media_lba            <= 32'h0;
      o_media_len            <= 32'h0;
      o_media_cache_bypass   <= 1'b1;
      o_din_valid            <= 1'b0;
      o_din_byte             <= 8'h00;
      o_done                 <= 1'b0;
      o_status               <= STAT_GOOD;
      o_sense_key            <= KEY_NONE;
      o_sense_asc            <= ASC_NONE;
      o_sense_valid          <= 1'b0;
      o_length_mismatch_flag <= 1'b0;
      o_sense_info           <= 32'h0;
      for (int i = 0; i < CDB_MAX; i++)
        cdb[i] <= 8'h00;
    end else begin
      state                  <= next_state;
      cdb_cnt                <= next_cdb_cnt;
      pos                    <= next_pos;
      limit                  <= next_limit;
      ret_fmt                <= next_ret_fmt;
      is_long                <= next_is_long;
      fin_status             <= next_fin_status;
      fin_key                <= next_fin_key;
      fin_asc                <= next_fin_asc;
      fin_valid              <= next_fin_valid;
      fin_lmf                <= next_fin_lmf;
      fin_info               <= next_fin_info;
      o_def_index            <= next_def_index;
      o_media_req            <= next_media_req;
      o_media_lba            <= next_media_lba;
      o_media_len            <= next_media_len;
      o_media_cache_bypass   <= 1'b1;
      o_din_valid            <= next_din_valid;
      o_din_byte             <= next_din_byte;
      o_done                 <= next_done;
      if (state == DLR_DONE) begin
        o_status               <= next_fin_status;
        o_sense_key            <= next_fin_key;
        o_sense_asc            <= next_fin_asc;
        o_sense_valid          <= next_fin_valid;
        o_length_mismatch_flag <= next_fin_lmf;
        o_sense_info           <= next_fin_info;
      end
      if (i_cdb_valid && (state == DLR_IDLE || state == DLR_CDB))
        cdb[cdb_wr] <= i_cdb_byte;
    end
  end
endmodule : dlr_cmd

//--- verification/dlr_cmd_asserts.sv
`timescale 1ns/1ns
module dlr_asserts
  import dlr_pkg::*;
(
  input wire logic       i_sys_clk,
  input wire logic       i_rst,
  input wire logic       i_din_ready,
  input wire logic       o_media_req,
  input wire logic       o_media_cache_bypass,
  input wire logic       o_din_valid,
  input wire logic [7:0] o_din_byte,
  input wire logic       o_done,
  input wire logic [1:0] o_status,
  input wire logic [3:0] o_sense_key,
  input wire logic [7:0] o_sense_asc,
  input wire logic       o_sense_valid,
  input wire logic       o_length_mismatch_flag
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  AST_BYPASS: assert property (o_media_cache_bypass)
    else $error("cache bypass low");
  AST_DONE_PULSE: assert property (o_done |=> !o_done)
    else $error("done longer than one cycle");
  AST_REQ_PULSE: assert property (o_media_req |=> !o_media_req)
    else $error("media request longer than one cycle");
  AST_DIN_HOLD: assert property (o_din_valid && !i_din_ready
    |=> o_din_valid && $stable(o_din_byte))
    else $error("data byte dropped before handshake");
  AST_DIN_GAP: assert property (o_din_valid && i_din_ready
    |=> !o_din_valid)
    else $error("data valid not lowered after handshake");
  AST_MISMATCH: assert property (o_done && o_length_mismatch_flag
    |-> o_status == STAT_CHECK && o_sense_key == KEY_ILLEGAL
    && o_sense_asc == ASC_INVALID_CDB && o_sense_valid)
    else $error("length mismatch sense wrong");
  AST_STAT_HELD: assert property (!o_done
    |-> $stable(o_status) && $stable(o_sense_key))
    else $error("status changed without done");
  AST_REQ_QUIET: assert property (o_media_req
    |-> !o_din_valid && !o_done)
    else $error("media request during transfer");
  AST_DONE_IDLE: assert property (o_done |-> !o_din_valid)
    else $error("data still offered at done");
  AST_GOOD_CLEAN: assert property (o_done && o_status == STAT_GOOD
    |-> !o_length_mismatch_flag)
    else $error("good status with mismatch flag");
endmodule : dlr_asserts
bind dlr_cmd dlr_asserts u_chk (.i_sys_clk, .i_rst, .i_din_ready,
  .o_media_req, .o_media_cache_bypass, .o_din_valid, .o_din_byte,
  .o_done, .o_status, .o_sense_key, .o_sense_asc, .o_sense_valid,
  .o_length_mismatch_flag);

//--- verification/dlr_media_model.sv
`timescale 1ns/1ns
module dlr_media_model (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  input  wire logic [31:0] i_salt,
  input  wire logic [15:0] i_idx,
  input  wire logic        i_req,
  input  wire logic [31:0] i_lba,
  input  wire logic        i_take,
  output logic      [23:0] o_cyl,
  output logic      [7:0]  o_head,
  output logic      [31:0] o_sector,
  output logic      [7:0]  o_byte,
  output logic             o_valid
);
  logic [15:0] ptr;
  logic [2:0]  tick;
  logic [7:0]  data;
  // defect table entry looked up at once
  assign o_cyl    = {i_salt[15:0], i_idx[7:0]};
  assign o_head   = i_idx[7:0] ^ i_salt[23:16];
  assign o_sector = i_salt + {16'h0000, i_idx} * 32'h00000101;
  // raw block byte, stalls one cycle in eight
  assign data     = i_lba[7:0] ^ (ptr[7:0] * 8'h1D);
  assign o_valid  = (tick != 3'h0);
  assign o_byte   = o_valid ? data : ~data;
  always_ff @(posedge i_sys_clk) begin
    tick <= i_rst ? 3'h0 : tick + 3'h1;
    if (i_rst || i_req) ptr <= 16'h0000;
    else if (i_take) ptr <= ptr + 16'h0001;
  end
endmodule : dlr_media_model

//--- verification/test_dlr_cmd.sv
`timescale 1ns/1ns
module test_dlr_cmd;
  import dlr_pkg::*;
  logic        i_sys_clk = 1'b0, i_rst = 1'b1;
  logic        i_cdb_valid = 1'b0, i_cdb_last = 1'b0;
  logic [7:0]  i_cdb_byte = 8'h00;
  logic [3:0]  i_lb_per_pb_exp = 4'h0;
  logic [15:0] i_lb_size = 16'h0010, i_bytes_per_sector = 16'h0200;
  logic [31:0] i_defect_count = 32'h0, salt = 32'h0, lba = 32'h0, r;
  logic        i_corr_failed = 1'b0, i_din_ready = 1'b0;
  logic [23:0] i_def_cyl;
  logic [7:0]  i_def_head, i_media_byte, o_din_byte, o_sense_asc;
  logic [31:0] i_def_sector, o_media_lba, o_media_len, o_sense_info;
  logic [15:0] o_def_index;
  logic        i_media_valid, o_media_req, o_media_cache_bypass, o_done;
  logic        o_din_valid, o_sense_valid, o_length_mismatch_flag;
  logic [1:0]  o_status;
  logic [3:0]  o_sense_key;
  logic [7:0]  cdb[$], exp_q[$], got[$];
  logic [31:0] rs = 32'h1B481776;
  int bad_count = 0, compares = 0;
  // long read cases: exponent, block bit, correct, fail, length offset
  int ex[8] = '{0, 0, 2, 2, 0, 1, 3, 0};
  int pb[8] = '{0, 1, 1, 0, 0, 1, 0, 0};
  int co[8] = '{0, 0, 0, 1, 0, 0, 1, 0};
  int fl[8] = '{0, 0, 1, 0, 0, 0, 1, 1};
  int dl[8] = '{0, 0, 0, 9, 3, -5, 0, 0}; // 9: zero length
  dlr_cmd dut (.i_sys_clk, .i_rst, .i_cdb_valid, .i_cdb_byte, .i_cdb_last,
    .i_lb_per_pb_exp, .i_lb_size, .i_bytes_per_sector, .i_defect_count,
    .i_def_cyl, .i_def_head, .i_def_sector, .i_media_byte, .i_media_valid,
    .i_corr_failed, .i_din_ready, .o_def_index, .o_media_req, .o_media_lba,
    .o_media_len, .o_media_cache_bypass, .o_din_valid, .o_din_byte,
    .o_done, .o_status, .o_sense_key, .o_sense_asc, .o_sense_valid,
    .o_length_mismatch_flag, .o_sense_info);
  dlr_media_model u_far (.i_sys_clk, .i_rst, .i_salt(salt),
    .i_idx(o_def_index), .i_req(o_media_req), .i_lba(o_media_lba),
    .i_take(o_din_valid && i_din_ready), .o_cyl(i_def_cyl),
    .o_head(i_def_head), .o_sector(i_def_sector), .o_byte(i_media_byte),
    .o_valid(i_media_valid));
  always #25 i_sys_clk = ~i_sys_clk;
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : rnd
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want) begin
      bad_count++;
      $display("CHECK FAILED %0t seen %h want %h", $time, seen, want);
    end
  endtask : chk
  task automatic put(input logic [31:0] v);
    for (int i = 3; i >= 0; i--) exp_q.push_back(v[8*i +: 8]);
  endtask : put
  task automatic run(input logic [1:0] st, input logic [3:0] key,
                     input logic [7:0] asc, input int nreq);
    int reqs;
    logic seen;
    reqs = 0;
    seen = 1'b0;
    got = {};
    foreach (cdb[i]) begin
      @(negedge i_sys_clk);
      i_cdb_valid = 1'b1;
      i_cdb_byte = cdb[i];
      i_cdb_last = (i == cdb.size() - 1);
    end
    for (int c = 0; c < 3000 && !seen; c++) begin
      @(negedge i_sys_clk);
      i_cdb_valid = 1'b0;
      i_cdb_last = 1'b0;
      i_din_ready = (rnd() % 4 != 0);
      if (o_din_valid && i_din_ready) got.push_back(o_din_byte);
      if (o_media_req) reqs++;
      if (o_media_req) chk(o_media_lba, lba);
      seen = o_done;
    end
    chk(seen, 1'b1);
    chk(got.size(), exp_q.size());
    foreach (exp_q[i]) if (i < got.size()) chk(got[i], exp_q[i]);
    chk(reqs, nreq);
    chk(o_status, st);
    if (st != STAT_GOOD) chk({o_sense_key, o_sense_asc}, {key, asc});
  endtask : run
  task automatic defect(input logic [2:0] fmt);
    logic [2:0]  rf;
    logic [31:0] al;
    logic [7:0]  b1;
    r = rnd();
    al = {26'h0, r[7:2]};
    i_defect_count = {30'h0, r[9:8]} + 32'h1;
    rf = (fmt == FMT_BYTE_INDEX || fmt == FMT_SECTOR) ? fmt : FMT_SECTOR;
    b1 = {3'h0, r[1:0], fmt};
    cdb = {OP_DEFECT_READ, b1, 8'h00, 8'h00, 8'h00, 8'h00, al[31:24],
           al[23:16], al[15:8], al[7:0], 8'h00, 8'h00};
    exp_q = {};
    put({8'h00, 3'h0, r[1:0], rf, 16'h0000});
    put(i_defect_count * 32'h8);
    for (int i = 0; i < i_defect_count; i++) begin
      put({salt[15:0], i[7:0], i[7:0] ^ salt[23:16]});
      put(rf == FMT_SECTOR ? salt + i * 32'h101
          : (salt + i * 32'h101) * {16'h0, i_bytes_per_sector});
    end
    while (exp_q.size() > al) void'(exp_q.pop_back());
    run(rf == fmt ? STAT_GOOD : STAT_CHECK, KEY_RECOVERED, ASC_NO_DEFECTS,
        0);
  endtask : defect
  task automatic longrd(input int k);
    logic [31:0] av, ln;
    logic [7:0]  b1;
    r = rnd();
    lba = rnd();
    i_lb_size = {11'h000, r[4:0]} + 16'h0010;
    i_lb_per_pb_exp = ex[k][3:0];
    i_corr_failed = fl[k][0];
    av = pb[k][0] ? {16'h0, i_lb_size} << ex[k]
                  : {16'h0, i_lb_size};
    ln = (dl[k] == 9) ? 32'h0 : av + dl[k];
    b1 = {5'h00, pb[k][0], co[k][0], 1'b0};
    cdb = {OP_LONG_READ, b1, lba[31:24], lba[23:16], lba[15:8], lba[7:0],
           8'h00, ln[15:8], ln[7:0], 8'h00};
    exp_q = {};
    if (ex[k] == 0 && pb[k] == 1) begin
      run(STAT_CHECK, KEY_ILLEGAL, ASC_INVALID_CDB, 0);
      chk({o_sense_valid, o_length_mismatch_flag}, 2'h0);
    end else if (dl[k] != 0 && dl[k] != 9) begin
      run(STAT_CHECK, KEY_ILLEGAL, ASC_INVALID_CDB, 0);
      chk({o_sense_valid, o_length_mismatch_flag}, 2'h3);
      chk(o_sense_info, ln - av);
    end else begin
      for (int i = 0; i < av; i++)
        exp_q.push_back(lba[7:0] ^ (i[7:0] * 8'h1D));
      run((co[k] && fl[k]) ? STAT_CHECK : STAT_GOOD, KEY_MEDIUM,
          ASC_UNRECOVERED, 1);
      chk(o_media_len, av);
      chk({o_sense_valid, o_length_mismatch_flag}, 2'h0);
    end
  endtask : longrd
  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    #3000000;
    bad_count++;
    finish_test();
  end
  initial begin
    repeat (20) @(negedge i_sys_clk);
    i_rst = 1'b0;
    @(negedge i_sys_clk);
    chk({o_media_cache_bypass, o_done, o_din_valid}, 3'h4);
    salt = rnd();
    r = rnd();
    i_bytes_per_sector = r[15:0];
    for (int f = 0; f < 8; f++) defect(f[2:0]);
    for (int k = 0; k < 8; k++) longrd(k);
    finish_test();
  end
endmodule : test_dlr_cmd
